/* File: hw/ouhbp_pkg.sv */
// Purpose: Shared constants for the octal UART host bus port
// Assumes: Single 25 MHz clock, synchronous active-low reset
// Notes: Field positions of the 8-bit address
package ouhbp_pkg;
	localparam int OUHBP_AW = 8;
	localparam int OUHBP_DW = 8;
	localparam int OUHBP_NCH = 8;
	localparam int OUHBP_NREG = 16;
	localparam int OUHBP_REG_LSB = 0;
	localparam int OUHBP_REG_MSB = 3;
	localparam int OUHBP_CH_LSB = 4;
	localparam int OUHBP_CH_MSB = 6;
	localparam int OUHBP_GLB_BIT = 7;
	localparam logic [3:0] OUHBP_GLB_ISR_OFS = 4'h0;
	localparam logic [7:0] OUHBP_BYTE_ZERO = 8'h00;
	localparam logic [1:0] OUHBP_SYNC_IDLE = 2'h3;
	localparam logic [2:0] OUHBP_CNT_ZERO = 3'h0;
	localparam logic [2:0] OUHBP_STROBE_LOW_CYC = 3'h4;
	localparam logic [2:0] OUHBP_SETUP_CYC = 3'h2;
	typedef enum logic [3:0]
	{
		OUHBP_H_IDLE = 4'h1,
		OUHBP_H_SETUP = 4'h2,
		OUHBP_H_STROBE = 4'h4,
		OUHBP_H_HOLD = 4'h8
	} ouhbp_hst_t;
endpackage

/* File: hw/ouhbp_if.sv */
// Purpose: Pin bundle between host processor bus and the octal UART port
// Assumes: Open-drain and two-way pins resolved by the testbench
// Notes: Enable high while a party drives
`timescale 1ns/1ns
interface ouhbp_if;
	logic [7:0] addr;
	logic [7:0] data_h;
	logic data_h_oe;
	logic [7:0] data_d;
	logic data_d_oe;
	logic read_strobe_n;
	logic write_strobe_n;
	logic chip_sel_n;
	logic bus_mode_sep;
	logic irq_n_oe;
	logic irq_n_in;
	modport dev
	(
		input addr, data_h, data_h_oe, read_strobe_n, write_strobe_n, chip_sel_n, bus_mode_sep, irq_n_in,
		output data_d, data_d_oe, irq_n_oe
	);
	modport host
	(
		input data_d, data_d_oe, irq_n_in,
		output addr, data_h, data_h_oe, read_strobe_n, write_strobe_n, chip_sel_n, bus_mode_sep
	);
endinterface

/* File: hw/ouhbp_dev.sv */
// Purpose: Device end: address decode, register access, shared interrupt
// Assumes: Pins come from outside the clock and pass two flip-flops
// Notes: Strobe edges are detected on synchronised pins
`timescale 1ns/1ns
// Contract
// RULE_01: A3..A0 select one of sixteen registers
// RULE_02: A6..A4 select channel zero to seven
// RULE_03: A7 selects global registers
// RULE_04: Mode pin high separate strobes, low single
// RULE_05: Read strobe fall drives addressed byte
// RULE_06: Write strobe trailing edge stores data byte
// RULE_07: Chip select gates strobes in separate mode
// RULE_08: Single mode: write pin is direction
// RULE_09: Single mode: chip select is strobe
// RULE_10: Single mode: host ties read strobe high
// RULE_11: Open-drain interrupt only pulls low
// RULE_12: Global register shows all channel interrupts
// RULE_13: Data bus driven only during reads
// RULE_14: Host holds address, direction during strobe
module ouhbp_dev
	import ouhbp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Bus pins
	ouhbp_if.dev bus,
	// Channel interrupt requests
	input wire logic [OUHBP_NCH-1:0] ch_irq,
	// Global register write port
	output logic glb_wr_q,
	output logic [3:0] glb_wr_ofs_q,
	output logic [7:0] glb_wr_data_q,
	// Read data for global registers other than the source register
	input wire logic [7:0] glb_rd_data
);
	// ****************************************
	// Synchronisers
	// ****************************************
	logic [7:0] addr_s1_q, addr_s2_q;
	logic [7:0] din_s1_q, din_s2_q;
	logic [1:0] rd_sync_q, wr_sync_q, cs_sync_q, mode_sync_q;
	logic [OUHBP_NCH-1:0] irq_s1_q, irq_s2_q;
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			rd_sync_q <= OUHBP_SYNC_IDLE;
			wr_sync_q <= OUHBP_SYNC_IDLE;
			cs_sync_q <= OUHBP_SYNC_IDLE;
			mode_sync_q <= OUHBP_SYNC_IDLE;
		end
		else
		begin
			rd_sync_q <= {rd_sync_q[0], bus.read_strobe_n};
			wr_sync_q <= {wr_sync_q[0], bus.write_strobe_n};
			cs_sync_q <= {cs_sync_q[0], bus.chip_sel_n};
			mode_sync_q <= {mode_sync_q[0], bus.bus_mode_sep};
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			addr_s1_q <= OUHBP_BYTE_ZERO;
			addr_s2_q <= OUHBP_BYTE_ZERO;
			din_s1_q <= OUHBP_BYTE_ZERO;
			din_s2_q <= OUHBP_BYTE_ZERO;
		end
		else
		begin
			addr_s1_q <= bus.addr;
			addr_s2_q <= addr_s1_q;
			din_s1_q <= bus.data_h;
			din_s2_q <= din_s1_q;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			irq_s1_q <= '0;
			irq_s2_q <= '0;
		end
		else
		begin
			irq_s1_q <= ch_irq;
			irq_s2_q <= irq_s1_q;
		end
	end

	// ****************************************
	// Access qualification
	// ****************************************
	logic sep_mode;
	logic rd_act, wr_act;
	logic rd_act_q, wr_act_q;
	assign sep_mode = mode_sync_q[1]; // RULE_04
	always_comb
	begin
		if (sep_mode)
		begin
			rd_act = !cs_sync_q[1] && !rd_sync_q[1]; // RULE_05 RULE_07
			wr_act = !cs_sync_q[1] && !wr_sync_q[1]; // RULE_06 RULE_07
		end
		else
		begin
			rd_act = !cs_sync_q[1] && wr_sync_q[1]; // RULE_08 RULE_09
			wr_act = !cs_sync_q[1] && !wr_sync_q[1]; // RULE_08 RULE_09
		end
	end
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
		end
		else
		begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
		end
	end

	// ****************************************
	// Address decode and register store
	// ****************************************
	logic [3:0] reg_ofs;
	logic [2:0] ch_sel;
	logic glb_sel;
	logic [7:0] regs_q [OUHBP_NCH][OUHBP_NREG];
	logic [7:0] wr_byte_q;
	logic [7:0] irq_src;
	assign reg_ofs = addr_s2_q[OUHBP_REG_MSB:OUHBP_REG_LSB]; // RULE_01
	assign ch_sel = addr_s2_q[OUHBP_CH_MSB:OUHBP_CH_LSB]; // RULE_02
	assign glb_sel = addr_s2_q[OUHBP_GLB_BIT]; // RULE_03
	assign irq_src = irq_s2_q; // RULE_12
	always_ff @(posedge clock)
	begin
		if (!rstn)
			wr_byte_q <= OUHBP_BYTE_ZERO;
		else if (wr_act)
			wr_byte_q <= din_s2_q;
	end
	generate
		for (genvar c = 0; c < OUHBP_NCH; c++)
		begin : g_ch
			for (genvar r = 0; r < OUHBP_NREG; r++)
			begin : g_reg
				always_ff @(posedge clock)
				begin
					if (!rstn)
						regs_q[c][r] <= OUHBP_BYTE_ZERO;
					else if (wr_act_q && !wr_act && !glb_sel && ch_sel == 3'(c) && reg_ofs == 4'(r))
						regs_q[c][r] <= wr_byte_q; // RULE_06
				end
			end
		end
	endgenerate
	always_ff @(posedge clock)
	begin
		if (!rstn)
			glb_wr_q <= 1'b0;
		else
			glb_wr_q <= wr_act_q && !wr_act && glb_sel; // RULE_03 RULE_06
	end
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			glb_wr_ofs_q <= OUHBP_GLB_ISR_OFS;
			glb_wr_data_q <= OUHBP_BYTE_ZERO;
		end
		else
		begin
			glb_wr_ofs_q <= reg_ofs;
			glb_wr_data_q <= wr_byte_q;
		end
	end

	// ****************************************
	// Read drive and interrupt
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rstn)
			bus.data_d_oe <= 1'b0;
		else
			bus.data_d_oe <= rd_act; // RULE_13
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			bus.data_d <= OUHBP_BYTE_ZERO;
		else if (rd_act && !rd_act_q)
		begin
			if (glb_sel)
				bus.data_d <= (reg_ofs == OUHBP_GLB_ISR_OFS) ? irq_src : glb_rd_data; // RULE_12
			else
				bus.data_d <= regs_q[ch_sel][reg_ofs]; // RULE_05
		end
	end
	always_ff @(posedge clock)
	begin
		if (!rstn)
			bus.irq_n_oe <= 1'b0;
		else
			bus.irq_n_oe <= |irq_src; // RULE_11
	end
endmodule

/* File: hw/ouhbp_host.sv */
// Purpose: Host end: runs one read or write access on the bus pins
// Assumes: Same clock as the device end
// Notes: Address and direction held through the whole strobe
`timescale 1ns/1ns
module ouhbp_host
	import ouhbp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Bus pins
	ouhbp_if.host bus,
	// Mode select
	input wire logic sep_mode,
	// Request
	input wire logic req,
	input wire logic req_wr,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	// Answer
	output logic busy_q,
	output logic done_q,
	output logic [7:0] rdata_q,
	output logic irq_q
);
	ouhbp_hst_t st_q;
	logic [2:0] cnt_q;
	logic wr_q;
	logic [1:0] irq_sync_q;
	logic [1:0] oe_sync_q;
	logic [7:0] d_s1_q, d_s2_q;
	// ****************************************
	// Access sequencer
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			st_q <= OUHBP_H_IDLE;
			cnt_q <= OUHBP_CNT_ZERO;
			wr_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= OUHBP_BYTE_ZERO;
			bus.addr <= OUHBP_BYTE_ZERO;
			bus.data_h <= OUHBP_BYTE_ZERO;
			bus.data_h_oe <= 1'b0;
			bus.read_strobe_n <= 1'b1;
			bus.write_strobe_n <= 1'b1;
			bus.chip_sel_n <= 1'b1;
			bus.bus_mode_sep <= 1'b1;
		end
		else
		begin
			done_q <= 1'b0;
			bus.bus_mode_sep <= sep_mode; // RULE_04
			case (st_q)
				OUHBP_H_IDLE:
				begin
					bus.read_strobe_n <= 1'b1; // RULE_10
					if (req)
					begin
						st_q <= OUHBP_H_SETUP;
						cnt_q <= OUHBP_SETUP_CYC;
						wr_q <= req_wr;
						busy_q <= 1'b1;
						bus.addr <= req_addr;
						bus.data_h <= req_wdata;
						bus.data_h_oe <= req_wr;
						bus.write_strobe_n <= sep_mode ? 1'b1 : !req_wr; // RULE_08 RULE_14
						bus.chip_sel_n <= sep_mode ? 1'b0 : 1'b1; // RULE_07
					end
				end
				OUHBP_H_SETUP:
				begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == OUHBP_CNT_ZERO)
					begin
						st_q <= OUHBP_H_STROBE;
						cnt_q <= OUHBP_STROBE_LOW_CYC;
						if (sep_mode)
						begin
							bus.read_strobe_n <= wr_q; // RULE_05
							bus.write_strobe_n <= !wr_q; // RULE_06
						end
						else
							bus.chip_sel_n <= 1'b0; // RULE_09
					end
				end
				OUHBP_H_STROBE:
				begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == OUHBP_CNT_ZERO)
					begin
						st_q <= OUHBP_H_HOLD;
						cnt_q <= OUHBP_SETUP_CYC;
						if (sep_mode)
						begin
							bus.read_strobe_n <= 1'b1;
							bus.write_strobe_n <= 1'b1;
						end
						else
							bus.chip_sel_n <= 1'b1;
					end
				end
				OUHBP_H_HOLD:
				begin
					cnt_q <= cnt_q - 3'h1;
					if (!wr_q && oe_sync_q[1] && cnt_q == OUHBP_SETUP_CYC)
						rdata_q <= d_s2_q; // RULE_05
					if (cnt_q == OUHBP_CNT_ZERO)
					begin
						st_q <= OUHBP_H_IDLE;
						busy_q <= 1'b0;
						done_q <= 1'b1;
						bus.data_h_oe <= 1'b0;
						bus.chip_sel_n <= 1'b1;
						bus.write_strobe_n <= 1'b1;
					end
				end
				default:
					st_q <= OUHBP_H_IDLE;
			endcase
		end
	end

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			irq_sync_q <= OUHBP_SYNC_IDLE;
			oe_sync_q <= '0;
			d_s1_q <= OUHBP_BYTE_ZERO;
			d_s2_q <= OUHBP_BYTE_ZERO;
			irq_q <= 1'b0;
		end
		else
		begin
			irq_sync_q <= {irq_sync_q[0], bus.irq_n_in};
			oe_sync_q <= {oe_sync_q[0], bus.data_d_oe};
			d_s1_q <= bus.data_d;
			d_s2_q <= d_s1_q;
			irq_q <= !irq_sync_q[1]; // RULE_11
		end
	end
endmodule

/* File: tb/ouhbp_properties.sv */
// Purpose: Pin checks for the host bus port
// Assumes: One clock, synchronous active-low reset
// Notes: Device read answer 2 to 4 edges
`timescale 1ns/1ns
module ouhbp_properties
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Bus pins
	input wire logic [7:0] addr,
	input wire logic data_h_oe,
	input wire logic data_d_oe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chip_sel_n,
	input wire logic bus_mode_sep
);
	// ****
	// Checks
	// ****
	logic rd_act;
	assign rd_act = !chip_sel_n && (bus_mode_sep ? !read_strobe_n : write_strobe_n);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	chk_oe_by_read: assert property (data_d_oe |-> $past(rd_act, 2) || $past(rd_act, 3) || $past(rd_act, 4))
		else $error("data driven without read");
	chk_sep_read_ans: assert property (bus_mode_sep && $rose(rd_act) |-> ##[2:4] data_d_oe)
		else $error("no answer to read strobe");
	chk_single_read_ans: assert property (!bus_mode_sep && $rose(rd_act) |-> ##[2:4] data_d_oe)
		else $error("no answer to single strobe read");
	chk_cs_gates: assert property (chip_sel_n [*5] |-> !data_d_oe)
		else $error("drive with chip select high");
	chk_write_no_drive: assert property ((!chip_sel_n && !write_strobe_n) [*4] |-> !data_d_oe)
		else $error("drive during write");
	chk_oe_release: assert property ($fell(rd_act) |-> ##[1:4] !data_d_oe)
		else $error("drive held after read");
	chk_bus_exclusive: assert property (!(data_d_oe && data_h_oe))
		else $error("both ends drive data");
	chk_addr_hold: assert property (!bus_mode_sep && !chip_sel_n && !$past(chip_sel_n)
		|-> $stable(addr) && $stable(write_strobe_n))
		else $error("address moved in strobe");
	chk_single_rd_idle: assert property (!bus_mode_sep |-> read_strobe_n)
		else $error("read strobe low in single mode");
endmodule

/* File: tb/octal_uart_host_bus_port_tb_top.sv */
// Purpose: Both ends joined, random accesses in both modes
// Assumes: Host and device share one clock
// Notes: Reads checked from queue at done
`timescale 1ns/1ns
module octal_uart_host_bus_port_tb_top;
	import ouhbp_pkg::*;
	// ****
	// Setup
	// ****
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic sep_mode = 1'b1;
	logic req = 1'b0;
	logic req_wr = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [7:0] req_wdata = 8'h00;
	logic [7:0] ch_irq = 8'h00;
	logic [7:0] glb_rd_data = 8'h00;
	logic busy_q, done_q, irq_q, glb_wr_q;
	logic [7:0] rdata_q, glb_wr_data_q, a, m;
	logic [3:0] glb_wr_ofs_q;
	logic [15:0] seed = 16'h8396;
	logic [8:0] rd_q[$];
	logic [8:0] rd_note;
	logic [11:0] wr_q[$];
	int errors = 0;
	int num_checks = 0;
	always #20 clock = ~clock;
	ouhbp_if bus ();
	assign bus.irq_n_in = bus.irq_n_oe ? 1'b0 : 1'b1;
	ouhbp_dev i_ouhbp_dev (.clock(clock), .rstn(rstn), .bus(bus.dev), .ch_irq(ch_irq), .glb_wr_q(glb_wr_q),
		.glb_wr_ofs_q(glb_wr_ofs_q), .glb_wr_data_q(glb_wr_data_q), .glb_rd_data(glb_rd_data));
	ouhbp_host i_ouhbp_host (.clock(clock), .rstn(rstn), .bus(bus.host), .sep_mode(sep_mode), .req(req),
		.req_wr(req_wr), .req_addr(req_addr), .req_wdata(req_wdata), .busy_q(busy_q), .done_q(done_q),
		.rdata_q(rdata_q), .irq_q(irq_q));
	ouhbp_properties i_ouhbp_properties (.clock(clock), .rstn(rstn), .addr(bus.addr), .data_h_oe(bus.data_h_oe),
		.data_d_oe(bus.data_d_oe), .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
		.chip_sel_n(bus.chip_sel_n), .bus_mode_sep(bus.bus_mode_sep));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic summarize();
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_gw(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic s, input logic w, input logic [7:0] ad, input logic [7:0] d, input logic [7:0] e);
		int n;
		rd_q.push_back({~w, e});
		if (w && ad[7])
			wr_q.push_back({ad[3:0], d});
		sep_mode = s;
		req_wr = w;
		req_addr = ad;
		req_wdata = d;
		req = 1'b1;
		@(negedge clock);
		req = 1'b0;
		for (n = 0; n < 100 && done_q !== 1'b1; n++)
			@(negedge clock);
		if (n == 100)
		begin
			errors++;
			summarize();
		end
	endtask
	// ****
	// Monitors
	// ****
	always @(negedge clock)
		if (done_q === 1'b1 && rd_q.size() > 0)
		begin
			rd_note = rd_q.pop_front();
			if (rd_note[8])
				chk_rd(rdata_q, rd_note[7:0]);
		end
	always @(negedge clock)
		if (glb_wr_q === 1'b1)
			chk_gw({glb_wr_ofs_q, glb_wr_data_q}, wr_q.size() > 0 ? wr_q.pop_front() : 12'hFFF);
	// ****
	// Stimulus
	// ****
	initial
	begin
		repeat (16) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		for (int i = 0; i < 16; i++)
		begin
			seed = lfsr(seed);
			a = {1'b0, seed[6:0]};
			m = i[1] ? 8'h70 : 8'h0F;
			ch_irq = i[2] ? seed[15:8] : 8'h00;
			glb_rd_data = seed[7:0];
			op(i[0], 1'b1, a, seed[15:8], 8'h00);
			op(i[0], 1'b1, a ^ m, ~seed[15:8], 8'h00);
			op(i[0], 1'b0, a, 8'h00, seed[15:8]);
			op(i[0], 1'b0, a ^ m, 8'h00, ~seed[15:8]);
			op(i[0], 1'b1, {1'b1, seed[14:8]}, seed[7:0], 8'h00);
			op(i[0], 1'b0, 8'h80, 8'h00, ch_irq);
			op(i[0], 1'b0, {4'h8, seed[3:0] | 4'h1}, 8'h00, glb_rd_data);
			chk_flag(irq_q, |ch_irq);
		end
		repeat (8) @(negedge clock);
		summarize();
	end
endmodule
